// >>> sim/pcrb_asserts.sv
// Port checker for the paged control register bank.
// Assumes it is bound onto the top module with its charge parameter.
`default_nettype none
module pcrb_asserts
	import paged_control_pkg::*;
#(
	parameter int QCHG_CYC3 = 40
) (
	input wire logic  clk_i,
	input wire logic  rst_n_i,
	input wire byte_t reg_addr_i,
	input wire byte_t reg_wdata_i,
	input wire logic  reg_wr_i,
	input wire logic  reg_rd_i,
	input wire byte_t reg_rdata_o,
	input wire logic  reg_rvalid_o,
	input wire byte_t page_o,
	input wire logic  analog_supply_high_i,
	input wire logic  io_supply_high_i,
	input wire logic  digital_regulator_en_o,
	input wire logic  reference_en_o,
	input wire logic  reference_fast_charge_o,
	input wire logic  analog_supply_direct_o,
	input wire logic  io_low_voltage_only_o,
	input wire logic  awake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	int charge_q;
	int charge_d;
	// Charge window length, saturating so a stuck window cannot wrap
	always_comb begin
		charge_d = 0;
		if (reference_fast_charge_o)
			charge_d = charge_q + int'(charge_q < 1000);
	end
	always_ff @(posedge clk_i) begin
		charge_q <= rst_n_i ? charge_d : 0;
	end
	a_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read strobe got no answer");
	a_no_idle_answer: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("answer without read strobe");
	a_page_write_lands: assert property (reg_wr_i && reg_addr_i == 8'h00
		|=> page_o == $past(reg_wdata_i))
		else $error("page selector not written");
	a_empty_page_reads: assert property (page_o != 8'h00 && reg_rd_i
		&& reg_addr_i != 8'h00 |=> reg_rdata_o == 8'h00)
		else $error("other page read not zero");
	a_ref_needs_awake: assert property (reference_en_o
		|-> $past(awake_o) && digital_regulator_en_o)
		else $error("reference on while asleep");
	a_asleep_regulator_off: assert property (!awake_o [*2]
		|-> !digital_regulator_en_o)
		else $error("regulator on while asleep");
	a_analog_override: assert property (analog_supply_high_i [*5]
		|-> !analog_supply_direct_o)
		else $error("analog mode not forced off");
	a_io_override: assert property (io_supply_high_i [*5]
		|-> !io_low_voltage_only_o)
		else $error("io mode not forced off");
	a_charge_with_ref: assert property (reference_fast_charge_o
		|-> reference_en_o)
		else $error("fast charge without reference");
	a_charge_bounded: assert property (charge_q <= QCHG_CYC3 + 4)
		else $error("fast charge window too long");
	c_charge_end: cover property ($fell(reference_fast_charge_o));
	c_top_page: cover property (reg_rvalid_o && page_o == 8'hff);
	c_override: cover property (analog_supply_high_i && io_supply_high_i);
endmodule : pcrb_asserts
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the paged control register bank.
// Assumes the checker module is compiled first; short charge counts.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import paged_control_pkg::*;
	localparam int CYC [4] = '{10, 20, 30, 40};
	logic        clk_i = 1'b0, rst_n_i = 1'b0;
	logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o;
	logic        analog_supply_high_i = 1'b0, io_supply_high_i = 1'b0;
	logic        digital_regulator_en_o, reference_en_o, awake_o;
	logic        reference_fast_charge_o;
	logic        analog_supply_direct_o, io_low_voltage_only_o;
	byte_t       reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
	byte_t       reg_rdata_o, page_o, got, d, p;
	byte_t       mem [128];
	int          error_cnt = 0, n_compared = 0, n;
	logic [31:0] seed = 32'h532c;

	paged_control_register_bank #(.QCHG_CYC0(CYC[0]), .QCHG_CYC1(CYC[1]),
		.QCHG_CYC2(CYC[2]), .QCHG_CYC3(CYC[3])) paged_control_register_bank_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.page_o(page_o), .analog_supply_high_i(analog_supply_high_i),
		.io_supply_high_i(io_supply_high_i),
		.digital_regulator_en_o(digital_regulator_en_o),
		.reference_en_o(reference_en_o),
		.reference_fast_charge_o(reference_fast_charge_o),
		.analog_supply_direct_o(analog_supply_direct_o),
		.io_low_voltage_only_o(io_low_voltage_only_o), .awake_o(awake_o));

	// 40 MHz device clock
	always #12.5 clk_i = ~clk_i;

	function automatic byte_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// Power-on value of each page-0 offset; unmapped places read zero
	function automatic byte_t dflt(byte_t a);
		case (a)
			8'h69, 8'h6e, 8'h70: return 8'hc9;
			8'h6a, 8'h6f, 8'h71, 8'h7a: return 8'h80;
			8'h6b, 8'h6c, 8'h6d: return 8'h20;
			8'h72, 8'h73: return 8'h18;
			8'h76: return 8'hcc;
			default: return 8'h00;
		endcase
	endfunction : dflt

	function automatic bit is_rw(byte_t a);
		return (a >= 8'h69 && a <= 8'h78 && a != 8'h74 && a != 8'h75)
			|| a == 8'h7e;
	endfunction : is_rw

	task automatic print_verdict();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic chk(input byte_t seen, input byte_t exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	task automatic wr(input byte_t a, input byte_t v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr

	// Strobe one cycle, then wait a bounded time for the answer
	task automatic rd(input byte_t a, output byte_t v);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		for (int i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		if (reg_rvalid_o !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
		v = reg_rdata_o;
	endtask : rd

	task automatic check_all();
		for (int a = 0; a < 128; a++) begin
			rd(byte_t'(a), got);
			chk(got, dflt(byte_t'(a)));
		end
	endtask : check_all

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		check_all();
		// Random fill of every offset but the page selector and the reset byte
		for (int a = 2; a < 128; a++) begin
			d = rnd();
			// Software keeps the reserved configuration bits at zero
			if (a == 2)
				d &= 8'h3f;
			mem[a] = (is_rw(byte_t'(a)) || a == 2) ? d : dflt(byte_t'(a));
			wr(byte_t'(a), d);
		end
		for (int a = 2; a < 128; a++) begin
			rd(byte_t'(a), got);
			chk(got, mem[a]);
		end
		// Sleep exit, regulator only
		wr(8'h02, 8'h00);
		wr(8'h02, 8'h01);
		repeat (2) @(posedge clk_i);
		chk({reference_en_o, digital_regulator_en_o, awake_o}, 8'h03);
		wr(8'h02, 8'h00);
		repeat (2) @(posedge clk_i);
		chk({reference_en_o, digital_regulator_en_o, awake_o}, 8'h00);
		// Each fast-charge code, window measured in cycles
		for (int c = 0; c < 4; c++) begin
			wr(8'h02, 8'h00);
			wr(8'h02, byte_t'(c << 4) | 8'h09);
			n = 0;
			for (int i = 0; i < 200 && (n == 0 || reference_fast_charge_o); i++) begin
				@(posedge clk_i);
				#1;
				n += int'(reference_fast_charge_o);
			end
			chk(byte_t'(n >= CYC[c] && n <= CYC[c] + 3), 8'h01);
			chk({reference_en_o, digital_regulator_en_o}, 8'h03);
		end
		// Supply override, sticky flags, then direct modes allowed
		@(posedge clk_i);
		analog_supply_high_i <= 1'b1;
		io_supply_high_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		wr(8'h02, 8'h06);
		rd(8'h02, got);
		chk(got, 8'h00);
		rd(8'h03, got);
		chk(got, 8'hc0);
		@(posedge clk_i);
		analog_supply_high_i <= 1'b0;
		io_supply_high_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		wr(8'h02, 8'h06);
		rd(8'h02, got);
		chk(got, 8'h06);
		chk({analog_supply_direct_o, io_low_voltage_only_o}, 8'h03);
		rd(8'h03, got);
		chk(got, 8'hc0);
		// Paging, top page included; other pages hold nothing
		wr(8'h69, 8'h5a);
		p = rnd() | 8'h01;
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, p);
			chk(page_o, p);
			rd(8'h00, got);
			chk(got, p);
			wr(8'h69, 8'h11);
			rd(8'h69, got);
			chk(got, 8'h00);
			p = 8'hff;
		end
		wr(8'h00, 8'h00);
		rd(8'h69, got);
		chk(got, 8'h5a);
		// Soft reset restores everything and clears itself
		wr(8'h01, 8'h01);
		repeat (3) @(posedge clk_i);
		check_all();
		print_verdict();
	end
endmodule : tb

bind paged_control_register_bank pcrb_asserts #(.QCHG_CYC3(QCHG_CYC3))
	pcrb_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .page_o(page_o),
	.analog_supply_high_i(analog_supply_high_i),
	.io_supply_high_i(io_supply_high_i),
	.digital_regulator_en_o(digital_regulator_en_o),
	.reference_en_o(reference_en_o),
	.reference_fast_charge_o(reference_fast_charge_o),
	.analog_supply_direct_o(analog_supply_direct_o),
	.io_low_voltage_only_o(io_low_voltage_only_o), .awake_o(awake_o));
`default_nettype wire

// >>> src/fast_charge_timer.sv
// Down-counter that times the reference fast-charge window.
// Assumes start_i is a one-cycle pulse on the device clock.
`default_nettype none
module fast_charge_timer #(
	parameter int WIDTH = 23
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             abort_i,
	input  wire logic             start_i,
	input  wire logic [WIDTH-1:0] cycles_i,
	output logic                  busy_o,
	output logic                  done_o
);
	logic [WIDTH-1:0] count_d;
	logic [WIDTH-1:0] count_q;
	logic             done_d;
	logic             done_q;

	// Load on start, count to one, then pulse done. Start outranks abort:
	// the sequencer raises start while it is still in its asleep state.
	always_comb begin
		count_d = count_q;
		done_d  = 1'b0;
		if (start_i)
			count_d = cycles_i;
		else if (abort_i)
			count_d = '0;
		else if (count_q != '0) begin
			count_d = count_q - 1'b1;
			done_d  = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count_q <= '0;
			done_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q  <= done_d;
		end
	end

	assign busy_o = (count_q != '0);
	assign done_o = done_q;
endmodule : fast_charge_timer
`default_nettype wire

// >>> src/paged_control_map.svh
// Offsets, field positions, reset values and timing figures of the
// paged control register bank.
// Assumes a 40 MHz device clock and an external control-port decoder.
//
// Behaviour
// - Eight-bit read/write page selector picks page
// - Writing one to reset restores all defaults
// - Reset bit clears itself after the reset
// - Fast-charge field picks 3.5/10/50/100 ms
// - Sleep exit enables regulator, optionally reference too
// - Analog mode bit: regulator or direct supply
// - I/O mode bit: wide range or fast
// - Active-low sleep bit, device starts asleep
// - Channel path setups default to C9/80
// - Enables CC, processing 18, status 80, outputs 20
// - Analog supply above 2 V forces mode, flags
// - I/O supply above 2 V forces mode, flags
`ifndef PAGED_CONTROL_MAP_SVH
`define PAGED_CONTROL_MAP_SVH

// Register offsets on page 0 (offset 0 is common to all pages)
`define OFS_PAGE_SELECT      8'h00
`define OFS_SOFT_RESET       8'h01
`define OFS_REF_SLEEP_CFG    8'h02
`define OFS_SUPPLY_STATUS    8'h03
`define OFS_DAC_1B_A         8'h69
`define OFS_DAC_1B_B         8'h6a
`define OFS_OUT2_A           8'h6b
`define OFS_OUT2_B           8'h6c
`define OFS_OUT2_C           8'h6d
`define OFS_DAC_2A_A         8'h6e
`define OFS_DAC_2A_B         8'h6f
`define OFS_DAC_2B_A         8'h70
`define OFS_DAC_2B_B         8'h71
`define OFS_DSP_A            8'h72
`define OFS_DSP_B            8'h73
`define OFS_CH_ENABLES       8'h76
`define OFS_DYN_POWER        8'h77
`define OFS_POWER_UP         8'h78
`define OFS_DEV_STATE_A      8'h79
`define OFS_DEV_STATE_B      8'h7a
`define OFS_CHECKSUM         8'h7e

// Reset values
`define RST_ZERO             8'h00
`define RST_DAC_SETUP_A      8'hc9
`define RST_DAC_SETUP_B      8'h80
`define RST_OUT_SETUP        8'h20
`define RST_DSP_SETUP        8'h18
`define RST_CH_ENABLES       8'hcc
`define RST_DEV_STATE_B      8'h80

// Field positions
`define BIT_SOFT_RESET       0
`define BIT_AWAKE_N_SLEEP    0
`define BIT_IO_LOW_ONLY      1
`define BIT_ANALOG_DIRECT    2
`define BIT_SLEEP_EXIT_REF   3
`define POS_FAST_CHARGE_LO   4
`define POS_FAST_CHARGE_HI   5
`define BIT_ANALOG_OVR_FLAG  7
`define BIT_IO_OVR_FLAG      6
`define MASK_REF_SLEEP_CFG   8'h3f

// Fast-charge times in microseconds and the clock rate
`define CLK_MHZ              40
`define QCHG_T0_US           3500
`define QCHG_T1_US           10000
`define QCHG_T2_US           50000
`define QCHG_T3_US           100000

`endif

// >>> src/paged_control_pkg.sv
// Types shared by the paged control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package paged_control_pkg;
	typedef logic [7:0] byte_t;

	// Power sequencing states
	typedef enum logic [1:0] {
		PWR_ASLEEP   = 2'b00,
		PWR_CHARGING = 2'b01,
		PWR_AWAKE    = 2'b10
	} power_state_e;
endpackage : paged_control_pkg
`default_nettype wire

// >>> src/paged_control_register_bank.sv
// Paged control register bank: page selector, soft reset, reference,
// sleep and supply configuration, and the page-0 setup registers.
// Assumes an external control-port decoder that presents one byte
// access per strobe on the device clock; supply comparators are async.
`include "paged_control_map.svh"
`default_nettype none
module paged_control_register_bank
	import paged_control_pkg::*;
#(
	parameter int TW        = 23,
	parameter int QCHG_CYC0 = `QCHG_T0_US * `CLK_MHZ,
	parameter int QCHG_CYC1 = `QCHG_T1_US * `CLK_MHZ,
	parameter int QCHG_CYC2 = `QCHG_T2_US * `CLK_MHZ,
	parameter int QCHG_CYC3 = `QCHG_T3_US * `CLK_MHZ
) (
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire byte_t reg_addr_i,
	input  wire byte_t reg_wdata_i,
	input  wire logic  reg_wr_i,
	input  wire logic  reg_rd_i,
	output byte_t      reg_rdata_o,
	output logic       reg_rvalid_o,
	output byte_t      page_o,
	input  wire logic  analog_supply_high_i,
	input  wire logic  io_supply_high_i,
	output logic       digital_regulator_en_o,
	output logic       reference_en_o,
	output logic       reference_fast_charge_o,
	output logic       analog_supply_direct_o,
	output logic       io_low_voltage_only_o,
	output logic       awake_o
);
	localparam int NREG = 15;

	// Plain read/write page-0 registers and their defaults
	localparam byte_t TBL_OFS [NREG] = '{
		`OFS_DAC_1B_A, `OFS_DAC_1B_B, `OFS_OUT2_A, `OFS_OUT2_B,
		`OFS_OUT2_C, `OFS_DAC_2A_A, `OFS_DAC_2A_B, `OFS_DAC_2B_A,
		`OFS_DAC_2B_B, `OFS_DSP_A, `OFS_DSP_B, `OFS_CH_ENABLES,
		`OFS_DYN_POWER, `OFS_POWER_UP, `OFS_CHECKSUM};
	localparam byte_t TBL_RST [NREG] = '{
		`RST_DAC_SETUP_A, `RST_DAC_SETUP_B, `RST_OUT_SETUP,
		`RST_OUT_SETUP, `RST_OUT_SETUP, `RST_DAC_SETUP_A,
		`RST_DAC_SETUP_B, `RST_DAC_SETUP_A, `RST_DAC_SETUP_B,
		`RST_DSP_SETUP, `RST_DSP_SETUP, `RST_CH_ENABLES,
		`RST_ZERO, `RST_ZERO, `RST_ZERO};

	// Table slot of an offset, NREG when none matches
	function automatic logic [3:0] slot_of(input byte_t a);
		logic [3:0] s;
		s = 4'(NREG);
		for (int i = 0; i < NREG; i++) begin
			if (a == TBL_OFS[i])
				s = 4'(i);
		end
		return s;
	endfunction : slot_of

	byte_t        page_d, page_q;
	logic         swrst_d, swrst_q;
	byte_t        cfg_d, cfg_q;
	logic         aflag_d, aflag_q;
	logic         ioflag_d, ioflag_q;
	byte_t        rdata_d, rdata_q;
	logic         rvalid_d, rvalid_q;
	power_state_e pst_d, pst_q;
	logic         digital_regulator_d, digital_regulator_q;
	logic         vref_d, vref_q;
	logic         qchg_d, qchg_q;
	logic [1:0]   asup_meta_q, iosup_meta_q;
	logic         asup_q, iosup_q;
	logic         on_page0;
	logic         any_access;
	logic [3:0]   wr_slot, rd_slot;
	byte_t        tbl_q [NREG];
	logic         t_start, t_busy, t_done;
	logic [TW-1:0] t_cycles;

	// Comparator levels come from the analog side: two-stage sync
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			asup_meta_q  <= 2'b00;
			iosup_meta_q <= 2'b00;
		end else begin
			asup_meta_q  <= {asup_meta_q[0], analog_supply_high_i};
			iosup_meta_q <= {iosup_meta_q[0], io_supply_high_i};
		end
	end
	assign asup_q  = asup_meta_q[1];
	assign iosup_q = iosup_meta_q[1];

	// Offset zero is decoded on every page; others only on page 0
	assign on_page0   = (page_q == 8'h00);
	assign any_access = reg_wr_i | reg_rd_i;
	assign wr_slot    = on_page0 ? slot_of(reg_addr_i) : 4'(NREG);
	assign rd_slot    = on_page0 ? slot_of(reg_addr_i) : 4'(NREG);

	// Setup registers, each cleared by the soft reset pulse
	generate
		for (genvar g = 0; g < NREG; g++) begin : g_setup
			setup_reg_cell #(
				.RESET_VALUE(TBL_RST[g])
			) u_cell (
				.clk_i  (clk_i),
				.rst_n_i(rst_n_i),
				.clr_i  (swrst_q),
				.we_i   (reg_wr_i && wr_slot == 4'(g)),
				.d_i    (reg_wdata_i),
				.q_o    (tbl_q[g])
			);
		end
	endgenerate

	// Control registers: page, soft reset, configuration, flags
	always_comb begin
		page_d   = page_q;
		swrst_d  = 1'b0;
		cfg_d    = cfg_q;
		aflag_d  = aflag_q | asup_q;
		ioflag_d = ioflag_q | iosup_q;
		if (swrst_q) begin
			page_d   = `RST_ZERO;
			cfg_d    = `RST_ZERO;
			aflag_d  = asup_q;
			ioflag_d = iosup_q;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `OFS_PAGE_SELECT)
				page_d = reg_wdata_i;
			else if (on_page0 && reg_addr_i == `OFS_SOFT_RESET)
				swrst_d = reg_wdata_i[`BIT_SOFT_RESET];
			else if (on_page0 && reg_addr_i == `OFS_REF_SLEEP_CFG)
				cfg_d = reg_wdata_i & `MASK_REF_SLEEP_CFG;
		end
		// A high supply overrides the low-voltage modes
		if (asup_q)
			cfg_d[`BIT_ANALOG_DIRECT] = 1'b0;
		if (iosup_q)
			cfg_d[`BIT_IO_LOW_ONLY] = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			page_q   <= `RST_ZERO;
			swrst_q  <= 1'b0;
			cfg_q    <= `RST_ZERO;
			aflag_q  <= 1'b0;
			ioflag_q <= 1'b0;
		end else begin
			page_q   <= page_d;
			swrst_q  <= swrst_d;
			cfg_q    <= cfg_d;
			aflag_q  <= aflag_d;
			ioflag_q <= ioflag_d;
		end
	end

	// Read path: one cycle latency, unmapped offsets read zero
	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = reg_rd_i;
		if (reg_rd_i) begin
			rdata_d = 8'h00;
			if (reg_addr_i == `OFS_PAGE_SELECT)
				rdata_d = page_q;
			else if (rd_slot != 4'(NREG))
				rdata_d = tbl_q[rd_slot];
			else if (on_page0) begin
				case (reg_addr_i)
					`OFS_SOFT_RESET:
						rdata_d = {7'h00, swrst_q};
					`OFS_REF_SLEEP_CFG:
						rdata_d = cfg_q;
					`OFS_SUPPLY_STATUS: begin
						rdata_d[`BIT_ANALOG_OVR_FLAG] = aflag_q;
						rdata_d[`BIT_IO_OVR_FLAG]     = ioflag_q;
					end
					`OFS_DEV_STATE_A:
						rdata_d = `RST_ZERO;
					`OFS_DEV_STATE_B:
						rdata_d = `RST_DEV_STATE_B;
					default:
						rdata_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Charge window from the selected time code
	always_comb begin
		case (cfg_q[`POS_FAST_CHARGE_HI:`POS_FAST_CHARGE_LO])
			2'd0:    t_cycles = TW'(QCHG_CYC0);
			2'd1:    t_cycles = TW'(QCHG_CYC1);
			2'd2:    t_cycles = TW'(QCHG_CYC2);
			default: t_cycles = TW'(QCHG_CYC3);
		endcase
	end

	fast_charge_timer #(
		.WIDTH(TW)
	) u_timer (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.abort_i (pst_q == PWR_ASLEEP),
		.start_i (t_start),
		.cycles_i(t_cycles),
		.busy_o  (t_busy),
		.done_o  (t_done)
	);

	// Sleep exit sequencing; the reference is charged only when it is enabled at a sleep exit
	always_comb begin
		pst_d   = pst_q;
		t_start = 1'b0;
		case (pst_q)
			PWR_ASLEEP: begin
				if (cfg_q[`BIT_AWAKE_N_SLEEP]) begin
					if (cfg_q[`BIT_SLEEP_EXIT_REF]) begin
						pst_d   = PWR_CHARGING;
						t_start = 1'b1;
					end else
						pst_d = PWR_AWAKE;
				end
			end
			PWR_CHARGING: begin
				if (!cfg_q[`BIT_AWAKE_N_SLEEP])
					pst_d = PWR_ASLEEP;
				else if (t_done)
					pst_d = PWR_AWAKE;
			end
			PWR_AWAKE: begin
				if (!cfg_q[`BIT_AWAKE_N_SLEEP])
					pst_d = PWR_ASLEEP;
			end
			default: pst_d = PWR_ASLEEP;
		endcase
		digital_regulator_d = (pst_d != PWR_ASLEEP);
		vref_d = digital_regulator_d && cfg_q[`BIT_SLEEP_EXIT_REF];
		qchg_d = (pst_d == PWR_CHARGING);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pst_q  <= PWR_ASLEEP;
			digital_regulator_q <= 1'b0;
			vref_q <= 1'b0;
			qchg_q <= 1'b0;
		end else begin
			pst_q  <= pst_d;
			digital_regulator_q <= digital_regulator_d;
			vref_q <= vref_d;
			qchg_q <= qchg_d;
		end
	end

	assign reg_rdata_o             = rdata_q;
	assign reg_rvalid_o            = rvalid_q;
	assign page_o                  = page_q;
	assign digital_regulator_en_o  = digital_regulator_q;
	assign reference_en_o          = vref_q;
	assign reference_fast_charge_o = qchg_q;
	assign analog_supply_direct_o  = cfg_q[`BIT_ANALOG_DIRECT];
	assign io_low_voltage_only_o   = cfg_q[`BIT_IO_LOW_ONLY];
	assign awake_o                 = cfg_q[`BIT_AWAKE_N_SLEEP];
endmodule : paged_control_register_bank
`default_nettype wire

// >>> src/setup_reg_cell.sv
// One plain read/write byte register with its own reset value.
// Assumes a synchronous active-low reset and a synchronous clear.
`default_nettype none
module setup_reg_cell
	import paged_control_pkg::*;
#(
	parameter byte_t RESET_VALUE = 8'h00
) (
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  clr_i,
	input  wire logic  we_i,
	input  wire byte_t d_i,
	output byte_t      q_o
);
	byte_t value_d;
	byte_t value_q;

	// Soft clear outranks a write in the same cycle
	always_comb begin
		value_d = value_q;
		if (clr_i)
			value_d = RESET_VALUE;
		else if (we_i)
			value_d = d_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			value_q <= RESET_VALUE;
		else
			value_q <= value_d;
	end

	assign q_o = value_q;
endmodule : setup_reg_cell
`default_nettype wire
